// ===== rtl/sga_consts.vh
`ifndef SGA_CONSTS_VH
`define SGA_CONSTS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SGA_ADDR_GAIN       8'hAA
`define SGA_ADDR_AGC_CTL    8'hB1
`define SGA_ADDR_HYST       8'hB3
`define SGA_ADDR_CEIL       8'hCF
`define SGA_ADDR_INT_STAT   8'hE0
`define SGA_ADDR_INT_MASK   8'hE1
`define SGA_ADDR_FLK_STAT   8'hE2

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SGA_GAIN_MSB        4
`define SGA_GAIN_LSB        0
`define SGA_HIGH_MSB        7
`define SGA_HIGH_LSB        6
`define SGA_LOW_MSB         5
`define SGA_LOW_LSB         4
`define SGA_PERS_MSB        2
`define SGA_PERS_LSB        0
`define SGA_AGC_EN_BIT      2
`define SGA_CEIL_MSB        3
`define SGA_CEIL_LSB        0
`define SGA_INT_LOWER       0
`define SGA_INT_RAISE       1
`define SGA_INT_FLICKER     2

// ----------------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------------
`define SGA_GAIN_RST        5'h09
`define SGA_GAIN_TOP        5'h0A
`define SGA_CEIL_RST        4'h9
`define SGA_CEIL_TOP        4'hA
`define SGA_HIGH_RST        2'h3
`define SGA_LOW_RST         2'h3
`define SGA_PERS_RST        3'h2
`define SGA_AGC_EN_RST      1'b0
`define SGA_INT_RST         3'h0

// ----------------------------------------------------------------------------
// Thresholds in eighths of full scale: high 4..7, low 1..4
// ----------------------------------------------------------------------------
`define SGA_HIGH_BASE       4'h4
`define SGA_LOW_BASE        4'h1

`endif

// ===== rtl/sga_thresh.v
`include "sga_consts.vh"

module sga_thresh #(
    parameter CNT_W  = 8,
    parameter SIZE_W = 16,
    parameter FS_W   = CNT_W + SIZE_W + 1
) (
    // Clock and reset
    input  wire              clk_i,
    input  wire              rstn_i,
    // Configuration
    input  wire [CNT_W-1:0]  step_count_i,
    input  wire [SIZE_W-1:0] step_size_i,
    input  wire [1:0]        high_code_i,
    input  wire [1:0]        low_code_i,
    // Thresholds
    output reg  [FS_W-1:0]   high_thr_o,
    output reg  [FS_W-1:0]   low_thr_o
);

    // ------------------------------------------------------------------------
    // Full scale
    // ------------------------------------------------------------------------
    wire [CNT_W:0]   cnt_p1;
    wire [SIZE_W:0]  size_p1;
    wire [FS_W-1:0]  full_scale;

    assign cnt_p1     = {1'b0, step_count_i} + {{CNT_W{1'b0}}, 1'b1};
    assign size_p1    = {1'b0, step_size_i} + {{SIZE_W{1'b0}}, 1'b1};
    assign full_scale = {{(FS_W-CNT_W-1){1'b0}}, cnt_p1} *
                        {{(FS_W-SIZE_W-1){1'b0}}, size_p1}; // [RULE_04]

    // Fraction in eighths; product kept wide so nothing is lost before the shift
    function [FS_W-1:0] frac8;
        input [FS_W-1:0] fs;
        input [3:0]      num;
        reg   [FS_W+3:0] p;
        begin
            p     = {4'h0, fs} * {{FS_W{1'b0}}, num};
            frac8 = p[FS_W+2:3];
        end
    endfunction

    // ------------------------------------------------------------------------
    // Registered thresholds
    // ------------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            high_thr_o <= {FS_W{1'b0}};
            low_thr_o  <= {FS_W{1'b0}};
        end else begin
            high_thr_o <= frac8(full_scale, `SGA_HIGH_BASE + {2'b00, high_code_i}); // [RULE_02]
            low_thr_o  <= frac8(full_scale, `SGA_LOW_BASE + {2'b00, low_code_i});   // [RULE_03]
        end
    end

endmodule // sga_thresh

// ===== rtl/sga_config.v
// Summary of operation
// [RULE_01] Gain code in bits 4:0 selects 0.5x at code 0 doubling up to 512x at code 10, reset 9.
// [RULE_02] With AGC on, gain steps down when data reaches 50/62.5/75/87.5 % of full scale.
// [RULE_03] With AGC on, gain steps up when data falls to 12.5/25/37.5/50 % of full scale.
// [RULE_04] Full scale is (step count + 1) times (step size + 1), computed internally.
// [RULE_05] Flicker status and its interrupt change only after 2^(code-1) differing results.
// [RULE_06] Automatic gain adjustment runs only while the AGC enable bit 2 is set, reset clear.
// [RULE_07] AGC never raises gain above the 4-bit ceiling in bits 3:0, reset 256x.
// [RULE_08] AGC gain stays within 0..10; unused codes and reserved bits have no effect.
`include "sga_consts.vh"

module sga_config #(
    parameter CNT_W  = 8,
    parameter SIZE_W = 16,
    parameter FS_W   = CNT_W + SIZE_W + 1
) (
    // Clock and reset
    input  wire              clk_i,
    input  wire              rstn_i,
    // Register port
    input  wire [7:0]        addr_i,
    input  wire [7:0]        wdata_i,
    input  wire              wr_i,
    input  wire              rd_i,
    output reg  [7:0]        rdata_o,
    // Measurement side
    input  wire [CNT_W-1:0]  integration_step_count_i,
    input  wire [SIZE_W-1:0] integration_step_size_i,
    input  wire              data_valid_i,
    input  wire [FS_W-1:0]   data_peak_i,
    input  wire              flicker_valid_i,
    input  wire              flicker_result_i,
    // Status and control out
    output wire [4:0]        spectral_gain_code_o,
    output wire              spectral_agc_enable_o,
    output wire              flicker_status_o,
    output wire              system_interrupt_o
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    reg  [4:0]      gain_reg;
    reg  [4:0]      gain_next;
    reg  [1:0]      high_reg;
    reg  [1:0]      low_reg;
    reg  [2:0]      pers_reg;
    reg             agc_en_reg;
    reg  [3:0]      ceil_reg;
    reg  [2:0]      int_stat_reg;
    reg  [2:0]      int_stat_next;
    reg  [2:0]      int_mask_reg;
    reg             flk_stat_reg;
    reg  [6:0]      flk_cnt_reg;
    reg  [6:0]      flk_cnt_next;
    reg             flk_stat_next;
    reg             ev_lower;
    reg             ev_raise;
    reg             ev_flicker;
    wire [FS_W-1:0] high_thr;
    wire [FS_W-1:0] low_thr;
    wire            wr_gain;
    wire            wr_hyst;
    wire            wr_ctl;
    wire            wr_ceil;

    assign wr_gain = wr_i && (addr_i == `SGA_ADDR_GAIN);
    assign wr_hyst = wr_i && (addr_i == `SGA_ADDR_HYST);
    assign wr_ctl  = wr_i && (addr_i == `SGA_ADDR_AGC_CTL);
    assign wr_ceil = wr_i && (addr_i == `SGA_ADDR_CEIL);

    // Run length of the flicker persistence filter; code 0 treated as one result
    function [6:0] run_len;
        input [2:0] code;
        begin
            if (code == 3'h0)
                run_len = 7'h01;
            else
                run_len = 7'h01 << (code - 3'h1);
        end
    endfunction

    // ------------------------------------------------------------------------
    // Threshold computation
    // ------------------------------------------------------------------------
    // Thresholds are registered, so a config change applies one cycle later
    sga_thresh #(
        .CNT_W  (CNT_W),
        .SIZE_W (SIZE_W),
        .FS_W   (FS_W)
    ) u_thresh (
        .clk_i        (clk_i),
        .rstn_i       (rstn_i),
        .step_count_i (integration_step_count_i),
        .step_size_i  (integration_step_size_i),
        .high_code_i  (high_reg),
        .low_code_i   (low_reg),
        .high_thr_o   (high_thr),
        .low_thr_o    (low_thr)
    );

    // ------------------------------------------------------------------------
    // Gain control
    // ------------------------------------------------------------------------
    // A software write of a valid code wins over an AGC step in the same cycle
    always @* begin
        gain_next = gain_reg;
        ev_lower  = 1'b0;
        ev_raise  = 1'b0;
        if (agc_en_reg && data_valid_i) begin // [RULE_06]
            if (data_peak_i >= high_thr) begin // [RULE_02]
                if (gain_reg != 5'h00) begin // [RULE_08]
                    gain_next = gain_reg - 5'h01;
                    ev_lower  = 1'b1;
                end
            end else if (data_peak_i <= low_thr) begin // [RULE_03]
                if ((gain_reg < {1'b0, ceil_reg}) && (gain_reg < `SGA_GAIN_TOP)) begin // [RULE_07]
                    gain_next = gain_reg + 5'h01;
                    ev_raise  = 1'b1;
                end
            end
        end
        if (wr_gain && (wdata_i[`SGA_GAIN_MSB:`SGA_GAIN_LSB] <= `SGA_GAIN_TOP)) begin // [RULE_08]
            gain_next = wdata_i[`SGA_GAIN_MSB:`SGA_GAIN_LSB]; // [RULE_01]
            ev_lower  = 1'b0;
            ev_raise  = 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Flicker persistence
    // ------------------------------------------------------------------------
    always @* begin
        flk_cnt_next  = flk_cnt_reg;
        flk_stat_next = flk_stat_reg;
        ev_flicker    = 1'b0;
        if (flicker_valid_i) begin
            if (flicker_result_i != flk_stat_reg) begin
                if ((flk_cnt_reg + 7'h01) >= run_len(pers_reg)) begin // [RULE_05]
                    flk_stat_next = flicker_result_i;
                    flk_cnt_next  = 7'h00;
                    ev_flicker    = 1'b1;
                end else begin
                    flk_cnt_next = flk_cnt_reg + 7'h01;
                end
            end else begin
                flk_cnt_next = 7'h00;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------------
    // A new event in the clearing cycle survives the clear
    always @* begin
        int_stat_next = int_stat_reg;
        if (wr_i && (addr_i == `SGA_ADDR_INT_STAT))
            int_stat_next = int_stat_reg & ~wdata_i[2:0];
        int_stat_next[`SGA_INT_LOWER]   = int_stat_next[`SGA_INT_LOWER] | ev_lower;
        int_stat_next[`SGA_INT_RAISE]   = int_stat_next[`SGA_INT_RAISE] | ev_raise;
        int_stat_next[`SGA_INT_FLICKER] = int_stat_next[`SGA_INT_FLICKER] | ev_flicker; // [RULE_05]
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            gain_reg     <= `SGA_GAIN_RST; // [RULE_01]
            high_reg     <= `SGA_HIGH_RST;
            low_reg      <= `SGA_LOW_RST;
            pers_reg     <= `SGA_PERS_RST;
            agc_en_reg   <= `SGA_AGC_EN_RST; // [RULE_06]
            ceil_reg     <= `SGA_CEIL_RST; // [RULE_07]
            int_stat_reg <= `SGA_INT_RST;
            int_mask_reg <= `SGA_INT_RST;
            flk_stat_reg <= 1'b0;
            flk_cnt_reg  <= 7'h00;
        end else begin
            gain_reg     <= gain_next;
            int_stat_reg <= int_stat_next;
            flk_stat_reg <= flk_stat_next;
            flk_cnt_reg  <= flk_cnt_next;
            if (wr_hyst) begin
                high_reg <= wdata_i[`SGA_HIGH_MSB:`SGA_HIGH_LSB];
                low_reg  <= wdata_i[`SGA_LOW_MSB:`SGA_LOW_LSB];
                pers_reg <= wdata_i[`SGA_PERS_MSB:`SGA_PERS_LSB];
            end
            if (wr_ctl)
                agc_en_reg <= wdata_i[`SGA_AGC_EN_BIT];
            if (wr_ceil && (wdata_i[`SGA_CEIL_MSB:`SGA_CEIL_LSB] <= `SGA_CEIL_TOP)) // [RULE_08]
                ceil_reg <= wdata_i[`SGA_CEIL_MSB:`SGA_CEIL_LSB];
            if (wr_i && (addr_i == `SGA_ADDR_INT_MASK))
                int_mask_reg <= wdata_i[2:0];
        end
    end

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    // Data stands only in the cycle after the strobe; unmapped reads give zero
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `SGA_ADDR_GAIN:     rdata_o <= {3'h0, gain_reg};
                `SGA_ADDR_HYST:     rdata_o <= {high_reg, low_reg, 1'b0, pers_reg};
                `SGA_ADDR_AGC_CTL:  rdata_o <= {5'h00, agc_en_reg, 2'h0};
                `SGA_ADDR_CEIL:     rdata_o <= {4'h0, ceil_reg};
                `SGA_ADDR_INT_STAT: rdata_o <= {5'h00, int_stat_reg};
                `SGA_ADDR_INT_MASK: rdata_o <= {5'h00, int_mask_reg};
                `SGA_ADDR_FLK_STAT: rdata_o <= {7'h00, flk_stat_reg};
                default:            rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    assign spectral_gain_code_o  = gain_reg;
    assign spectral_agc_enable_o = agc_en_reg;
    assign flicker_status_o      = flk_stat_reg;
    assign system_interrupt_o    = |(int_stat_reg & int_mask_reg);

endmodule // sga_config

// ===== dv/sga_config_assertions.sv
`include "sga_consts.vh"

module sga_config_assertions (
    // Clock and reset
    input wire       clk_i,
    input wire       rstn_i,
    // Register and event inputs
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire       wr_i,
    input wire       data_valid_i,
    input wire       flicker_valid_i,
    input wire       flicker_result_i,
    // Outputs
    input wire [4:0] spectral_gain_code_o,
    input wire       spectral_agc_enable_o,
    input wire       flicker_status_o
);
    timeunit 1ns;
    timeprecision 1ns;
    wire [4:0] g  = spectral_gain_code_o;
    wire       gw = wr_i && addr_i == `SGA_ADDR_GAIN;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    a_gain_range: assert property (g <= 5'h0A) else $error("gain code out of range");
    a_gain_write: assert property ($past(gw && wdata_i[4:0] <= 5'h0A) |->
        g == $past(wdata_i[4:0])) else $error("gain write not applied");
    a_gain_refuse: assert property ($past(gw && wdata_i[4:0] > 5'h0A && !data_valid_i) |->
        $stable(g)) else $error("unused gain code applied");
    a_step_one: assert property ($changed(g) && !$past(gw) |->
        g == $past(g) + 5'h01 || g + 5'h01 == $past(g)) else $error("gain step not one");
    a_step_cause: assert property ($changed(g) && !$past(gw) |->
        $past(data_valid_i && spectral_agc_enable_o)) else $error("gain moved without cause");
    a_enable_write: assert property ($past(wr_i && addr_i == `SGA_ADDR_AGC_CTL) |->
        spectral_agc_enable_o == $past(wdata_i[2])) else $error("enable write lost");
    a_flk_cause: assert property ($changed(flicker_status_o) |->
        $past(flicker_valid_i && flicker_result_i != flicker_status_o))
        else $error("flicker status moved without result");
    a_flk_hold: assert property (!flicker_valid_i |=> $stable(flicker_status_o))
        else $error("flicker status moved while idle");

    cover property ($changed(g) && !$past(gw));
    cover property ($changed(flicker_status_o));
    cover property (gw && wdata_i[4:0] > 5'h0A);
endmodule // sga_config_assertions

// ===== dv/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  cnt = 8'h00;
    logic [15:0] size = 16'h0007;
    logic        dv = 1'b0;
    logic [24:0] peak = 25'h0;
    logic        fv = 1'b0;
    logic        fr = 1'b0;
    wire  [7:0]  rdata;
    wire  [4:0]  gain;
    wire         irq;
    wire         agc_en;
    wire         flk;
    logic [7:0]  exp_q[$];
    logic        rd_q = 1'b0;
    logic [31:0] seed = 32'h6355FB76;
    int          bad_count = 0;
    int          n_checks = 0;

    sga_config dut (
        .clk_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .integration_step_count_i(cnt), .integration_step_size_i(size),
        .data_valid_i(dv), .data_peak_i(peak), .flicker_valid_i(fv), .flicker_result_i(fr),
        .spectral_gain_code_o(gain), .spectral_agc_enable_o(agc_en), .flicker_status_o(flk),
        .system_interrupt_o(irq));

    initial begin
        forever #20 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask

    // Kind 0: measurement peak, kind 1: flicker result in bit 0
    task automatic ev(input logic k, input logic [24:0] p);
        @(posedge clk);
        peak <= p;
        fr <= p[0];
        dv <= ~k;
        fv <= k;
        @(posedge clk);
        dv <= 1'b0;
        fv <= 1'b0;
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge clk) begin
        if (rd_q) begin
            chk(rdata, exp_q.pop_front());
        end
        rd_q <= rd;
    end

    initial begin
        repeat (6000) @(posedge clk);
        bad_count++;
        wrap_up;
    end

    initial begin
        logic [4:0] g;
        logic       s;
        int         n;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(8'hAA, 8'h09);
        rd_reg(8'hB3, 8'hF2);
        rd_reg(8'hB1, 8'h00);
        rd_reg(8'hCF, 8'h09);
        rd_reg(8'hE0, 8'h00);
        rd_reg(8'h10, 8'h00);
        g = 5'h09;
        repeat (8) begin
            seed = lfsr(seed);
            wr_reg(8'hAA, seed[7:0]);
            if (seed[4:0] <= 5'h0A) g = seed[4:0];
            rd_reg(8'hAA, {3'h0, g});
        end
        // ----------------------------------------------------------------
        // Gain control, full scale of 8 counts
        // ----------------------------------------------------------------
        wr_reg(8'hAA, 8'h09);
        wr_reg(8'hE1, 8'h07);
        ev(1'b0, 25'd7);
        rd_reg(8'hAA, 8'h09);
        wr_reg(8'hB1, 8'h04);
        // Outputs move on the write edge; look once they have settled
        @(negedge clk);
        chk({7'h0, agc_en}, 8'h01);
        ev(1'b0, 25'd7);
        rd_reg(8'hAA, 8'h08);
        @(negedge clk);
        chk({7'h0, irq}, 8'h01);
        chk({3'h0, gain}, 8'h08);
        rd_reg(8'hE0, 8'h01);
        wr_reg(8'hE0, 8'h01);
        rd_reg(8'hE0, 8'h00);
        @(negedge clk);
        chk({7'h0, irq}, 8'h00);
        for (int h = 0; h < 4; h++) begin
            wr_reg(8'hB3, {h[1:0], 6'h02});
            wr_reg(8'hAA, 8'h05);
            ev(1'b0, 25'(3 + h));
            ev(1'b0, 25'(4 + h));
            rd_reg(8'hAA, 8'h04);
        end
        for (int l = 0; l < 4; l++) begin
            wr_reg(8'hB3, {2'h3, l[1:0], 4'h2});
            wr_reg(8'hAA, 8'h05);
            ev(1'b0, 25'(2 + l));
            ev(1'b0, 25'(1 + l));
            rd_reg(8'hAA, 8'h06);
        end
        rd_reg(8'hE0, 8'h03);
        wr_reg(8'hE0, 8'hFF);
        wr_reg(8'hE1, 8'h00);
        ev(1'b0, 25'd0);
        rd_reg(8'hE0, 8'h02);
        @(negedge clk);
        chk({7'h0, irq}, 8'h00);
        wr_reg(8'hCF, 8'h05);
        wr_reg(8'hAA, 8'h05);
        ev(1'b0, 25'd0);
        rd_reg(8'hAA, 8'h05);
        wr_reg(8'hCF, 8'h0B);
        rd_reg(8'hCF, 8'h05);
        wr_reg(8'hCF, 8'h0A);
        wr_reg(8'hAA, 8'h0A);
        ev(1'b0, 25'd0);
        rd_reg(8'hAA, 8'h0A);
        wr_reg(8'hAA, 8'h00);
        ev(1'b0, 25'd7);
        rd_reg(8'hAA, 8'h00);
        // Full scale 3 x 2 = 6: high mark 5, low mark 3
        wr_reg(8'hB3, 8'hF2);
        cnt <= 8'h02;
        size <= 16'h0001;
        wr_reg(8'hAA, 8'h05);
        ev(1'b0, 25'd4);
        ev(1'b0, 25'd5);
        ev(1'b0, 25'd3);
        rd_reg(8'hAA, 8'h05);
        // ----------------------------------------------------------------
        // Flicker persistence
        // ----------------------------------------------------------------
        wr_reg(8'hE0, 8'hFF);
        wr_reg(8'hE1, 8'h04);
        s = 1'b0;
        for (int p = 0; p < 4; p++) begin
            n = (p == 0) ? 1 : (1 << (p - 1));
            wr_reg(8'hB3, {5'h1E, p[2:0]});
            repeat (n - 1) ev(1'b1, {24'h0, ~s});
            rd_reg(8'hE2, {7'h0, s});
            ev(1'b1, {24'h0, ~s});
            s = ~s;
            rd_reg(8'hE2, {7'h0, s});
            chk({7'h0, flk}, {7'h0, s});
        end
        @(negedge clk);
        chk({7'h0, irq}, 8'h01);
        repeat (3) ev(1'b1, {24'h0, ~s});
        ev(1'b1, {24'h0, s});
        repeat (3) ev(1'b1, {24'h0, ~s});
        rd_reg(8'hE2, {7'h0, s});
        // Second reset in mid-run
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(8'hAA, 8'h09);
        rd_reg(8'hE2, 8'h00);
        repeat (2) @(posedge clk);
        wrap_up;
    end
endmodule // tb_top

bind sga_config sga_config_assertions u_chk (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .data_valid_i(data_valid_i), .flicker_valid_i(flicker_valid_i),
    .flicker_result_i(flicker_result_i), .spectral_gain_code_o(spectral_gain_code_o),
    .spectral_agc_enable_o(spectral_agc_enable_o), .flicker_status_o(flicker_status_o));
